// *** pkg/ctw_params.svh ***
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH
`define CTW_ADDR_ID_CMD 2'h0
`define CTW_ADDR_GEN_CFG 2'h2
`define CTW_CFG_RESET 16'h0000
`define CTW_CMD_TOKEN_BIT 0
`define CTW_CMD_WDOG_BIT 1
`define CTW_CMD_SOFT_RST_BIT 2
`define CTW_CFG_WDOG_DIS 0
`define CTW_CFG_PRIO 1
`define CTW_CFG_RING_DIS 2
`define CTW_CFG_STAMP_BIN 3
`define CTW_CFG_SYNC_DIV 4
`define CTW_CFG_HDLC_IN7 5
`define CTW_CFG_FRAME_LO 6
`define CTW_CFG_FRAME_HI 7
`define CTW_CFG_BIT_CLK 8
`define CTW_STAMP_START 16'hFFFF
`define CTW_DEC_START 16'h9999
`define CTW_DIV32 6'h1F
`define CTW_DIV30 6'h1D
`define CTW_CLK_HZ 50000000
`define CTW_STEP_MS 250
`endif

// *** pkg/ctw_pkg.sv ***
`default_nettype none
package ctw_pkg;
  typedef enum logic [1:0] {
    CTW_FRAME_PLAIN,
    CTW_FRAME_GCI,
    CTW_FRAME_VSTAR,
    CTW_FRAME_UNUSED
  } ctw_frame_type;
  typedef enum {
    CTW_TOK_IDLE,
    CTW_TOK_HELD,
    CTW_TOK_PASS
  } ctw_tok_state_type;
endpackage
`default_nettype wire

// *** design/ctw_stamp_counter.sv ***
`include "ctw_params.svh"
`default_nettype none
module ctw_stamp_counter
  import ctw_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_step,
  input wire logic i_binary,
  input wire logic i_restart,
  // Count
  output logic [15:0] o_count
);
  logic [15:0] count_reg;
  logic [15:0] count_next;

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (borrow) begin
        if (r[d*4 +: 4] == 4'h0) begin
          r[d*4 +: 4] = 4'h9;
        end else begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  assign count_next = i_binary ? 16'(count_reg - 16'h0001)
                               : bcd_dec(count_reg);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      // Config leaves reset in decimal mode, whatever the old mode was
      count_reg <= `CTW_DEC_START;
    end else if (i_restart) begin
      count_reg <= i_binary ? `CTW_STAMP_START : `CTW_DEC_START;
    end else if (i_step) begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;
endmodule
`default_nettype wire

// *** design/ctw_regs.sv ***
`include "ctw_params.svh"
`default_nettype none
module ctw_regs
  import ctw_pkg::*;
#(
  // Arbitrary value
  parameter logic [15:0] ID_CODE = 16'h5A5A,
  parameter int STEP_CYCLES = `CTW_CLK_HZ / 1000 * `CTW_STEP_MS
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Processor register port
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // Token ring
  input wire logic i_token_in,
  input wire logic i_mem_req,
  output logic o_mem_grant,
  output logic o_token_out,
  // Watchdog
  input wire logic [15:0] i_timer_limit,
  output logic o_watchdog_out,
  // Time stamp
  output logic [15:0] o_stamp,
  // Circuit-wide reset
  output logic o_circuit_reset_n,
  // Sync and matrix
  input wire logic i_vcxo_tick,
  output logic o_vcxo_sync,
  input wire logic i_hdlc_tx_seven,
  input wire logic i_matrix_serial_in_seven,
  output logic o_matrix_in_seven,
  output ctw_frame_type o_frame_type,
  output logic o_bit_clock_rate
);
  // ---------------------------------------------
  // Register decode
  // ---------------------------------------------
  logic [15:0] general_config_reg;
  logic [15:0] general_config_next;
  logic sys_reset_n;
  logic soft_reset_reg;
  wire wr_cmd = i_cs && i_wr && (i_addr == `CTW_ADDR_ID_CMD);
  wire wr_cfg = i_cs && i_wr && (i_addr == `CTW_ADDR_GEN_CFG);
  // only ones on live bits act
  wire cmd_token = wr_cmd && i_wdata[`CTW_CMD_TOKEN_BIT];
  wire cmd_wdog = wr_cmd && i_wdata[`CTW_CMD_WDOG_BIT];
  wire cmd_soft = wr_cmd && i_wdata[`CTW_CMD_SOFT_RST_BIT];

  wire cfg_wdog_dis = general_config_reg[`CTW_CFG_WDOG_DIS];
  wire cfg_prio = general_config_reg[`CTW_CFG_PRIO];
  wire cfg_ring_dis = general_config_reg[`CTW_CFG_RING_DIS];
  wire cfg_stamp_bin = general_config_reg[`CTW_CFG_STAMP_BIN];
  wire cfg_sync_div = general_config_reg[`CTW_CFG_SYNC_DIV];
  wire cfg_hdlc_in7 = general_config_reg[`CTW_CFG_HDLC_IN7];

  assign sys_reset_n = i_reset_n && !soft_reset_reg;
  assign o_circuit_reset_n = sys_reset_n;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= cmd_soft;
    end
  end

  // Spare bits stay readable and writable
  assign general_config_next = wr_cfg ? i_wdata : general_config_reg;

  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      general_config_reg <= `CTW_CFG_RESET;
    end else begin
      general_config_reg <= general_config_next;
    end
  end

  // ---------------------------------------------
  // Read path
  // ---------------------------------------------
  logic [15:0] rdata_reg;
  wire [15:0] rd_mux = (i_addr == `CTW_ADDR_ID_CMD) ? ID_CODE :
                       (i_addr == `CTW_ADDR_GEN_CFG) ? general_config_reg :
                       16'h0000;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rdata_reg <= 16'h0000;
    end else if (i_cs && !i_wr) begin
      rdata_reg <= rd_mux;
    end
  end
  assign o_rdata = rdata_reg;

  // ---------------------------------------------
  // 250 ms step divider and stamp counter
  // ---------------------------------------------
  logic [23:0] step_cnt_reg;
  wire step = (step_cnt_reg == 24'(STEP_CYCLES - 1));
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n || step) begin
      step_cnt_reg <= 24'h00_0000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 24'h00_0001;
    end
  end

  logic stamp_bin_d_reg;
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      stamp_bin_d_reg <= 1'b0;
    end else begin
      stamp_bin_d_reg <= cfg_stamp_bin;
    end
  end
  // Mode change restarts the count from its proper start value
  wire stamp_restart = (stamp_bin_d_reg != cfg_stamp_bin) ||
                       (!cfg_stamp_bin && cmd_wdog);

  ctw_stamp_counter u_stamp (
    .i_mclk(i_mclk),
    .i_reset_n(sys_reset_n),
    .i_step(step),
    .i_binary(cfg_stamp_bin),
    .i_restart(stamp_restart),
    .o_count(o_stamp)
  );

  // ---------------------------------------------
  // Watchdog
  // ---------------------------------------------
  logic [15:0] wdog_cnt_reg;
  logic wdog_out_reg;
  wire wdog_expired = (wdog_cnt_reg >= i_timer_limit);
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      wdog_cnt_reg <= 16'h0000;
    end else if (cmd_wdog) begin
      wdog_cnt_reg <= 16'h0000;
    end else if (step && !wdog_expired) begin
      wdog_cnt_reg <= wdog_cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      wdog_out_reg <= 1'b0;
    end else if (cfg_wdog_dis || cmd_wdog) begin
      wdog_out_reg <= 1'b0;
    end else if (wdog_expired) begin
      wdog_out_reg <= 1'b1;
    end
  end
  assign o_watchdog_out = wdog_out_reg;

  // ---------------------------------------------
  // Token ring
  // ---------------------------------------------
  logic token_in_meta_reg;
  logic token_in_sync_reg;
  logic token_in_prev_reg;
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      token_in_meta_reg <= 1'b0;
      token_in_sync_reg <= 1'b0;
      token_in_prev_reg <= 1'b0;
    end else begin
      token_in_meta_reg <= i_token_in;
      token_in_sync_reg <= token_in_meta_reg;
      token_in_prev_reg <= token_in_sync_reg;
    end
  end
  wire token_arrive = token_in_sync_reg && !token_in_prev_reg;

  ctw_tok_state_type tok_state_reg;
  ctw_tok_state_type tok_state_next;
  logic token_out_reg;
  logic token_out_next;

  always_comb begin
    tok_state_next = tok_state_reg;
    token_out_next = 1'b0;
    case (tok_state_reg)
      CTW_TOK_IDLE: begin
        if (token_arrive || cmd_token) begin
          tok_state_next = CTW_TOK_HELD;
        end
      end
      CTW_TOK_HELD: begin
        if (!cfg_prio && i_mem_req) begin
          tok_state_next = CTW_TOK_PASS;
        end else if (!cfg_prio) begin
          tok_state_next = CTW_TOK_PASS;
        end
      end
      CTW_TOK_PASS: begin
        tok_state_next = CTW_TOK_IDLE;
        token_out_next = 1'b1;
      end
      default: begin
        tok_state_next = CTW_TOK_IDLE;
      end
    endcase
    if (cfg_ring_dis) begin
      tok_state_next = CTW_TOK_IDLE;
      token_out_next = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      tok_state_reg <= CTW_TOK_IDLE;
      token_out_reg <= 1'b0;
    end else begin
      tok_state_reg <= tok_state_next;
      token_out_reg <= token_out_next;
    end
  end
  assign o_token_out = token_out_reg;
  assign o_mem_grant = (tok_state_reg == CTW_TOK_HELD) && !cfg_ring_dis;

  // ---------------------------------------------
  // VCXO sync divider
  // ---------------------------------------------
  logic [5:0] vcxo_cnt_reg;
  logic vcxo_sync_reg;
  wire [5:0] vcxo_last = cfg_sync_div ? `CTW_DIV32 : `CTW_DIV30;
  wire vcxo_wrap = i_vcxo_tick && (vcxo_cnt_reg >= vcxo_last);
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      vcxo_cnt_reg <= 6'h00;
      vcxo_sync_reg <= 1'b0;
    end else begin
      vcxo_sync_reg <= vcxo_wrap;
      if (vcxo_wrap) begin
        vcxo_cnt_reg <= 6'h00;
      end else if (i_vcxo_tick) begin
        vcxo_cnt_reg <= vcxo_cnt_reg + 6'h01;
      end
    end
  end
  assign o_vcxo_sync = vcxo_sync_reg;

  // ---------------------------------------------
  // Matrix input seven and line formats
  // ---------------------------------------------
  logic matrix_in7_reg;
  always_ff @(posedge i_mclk) begin
    if (!sys_reset_n) begin
      matrix_in7_reg <= 1'b0;
    end else begin
      matrix_in7_reg <= cfg_hdlc_in7 ? i_hdlc_tx_seven
                                     : i_matrix_serial_in_seven;
    end
  end
  assign o_matrix_in_seven = matrix_in7_reg;

  assign o_frame_type = ctw_frame_type'({
    general_config_reg[`CTW_CFG_FRAME_HI],
    general_config_reg[`CTW_CFG_FRAME_LO]});
  assign o_bit_clock_rate = general_config_reg[`CTW_CFG_BIT_CLK];
endmodule
`default_nettype wire

// *** verif/ctw_regs_assertions.sv ***
`default_nettype none
module ctw_regs_checker
  import ctw_pkg::*;
#(
  // Arbitrary value
  parameter logic [15:0] ID_CODE = 16'h5A5A
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Register port
  input wire logic i_cs,
  input wire logic i_wr,
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] o_rdata,
  // Observed outputs
  input wire logic o_token_out,
  input wire logic o_mem_grant,
  input wire logic o_watchdog_out,
  input wire logic o_circuit_reset_n,
  input wire logic o_vcxo_sync,
  input wire ctw_frame_type o_frame_type,
  input wire logic o_bit_clock_rate
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire logic wr_cmd = i_cs && i_wr && i_addr == 2'h0;
  wire logic wr_cfg = i_cs && i_wr && i_addr == 2'h2;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  id_read_a: assert property (
    i_cs && !i_wr && i_addr == 2'h0 |=> o_rdata == ID_CODE)
    else $error("identity read wrong");
  unmapped_read_a: assert property (
    i_cs && !i_wr && i_addr[0] |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  soft_rst_a: assert property (
    wr_cmd && i_wdata[2] |=> !o_circuit_reset_n ##1 o_circuit_reset_n)
    else $error("soft reset pulse wrong");
  no_cmd_a: assert property (
    wr_cmd && i_wdata[2:0] == 3'h0 |=> o_circuit_reset_n)
    else $error("reset without command");
  tok_pulse_a: assert property (
    o_token_out |=> !o_token_out)
    else $error("token pulse too long");
  wdog_low_a: assert property (
    wr_cfg && i_wdata[0] |=> ##1 !o_watchdog_out [*8])
    else $error("watchdog high while disabled");
  ring_dis_a: assert property (
    wr_cfg && i_wdata[2] |=> ##2 (!o_token_out && !o_mem_grant) [*6])
    else $error("token alive with ring off");
  frame_cfg_a: assert property (
    wr_cfg |=> o_frame_type == $past(i_wdata[7:6])
      && o_bit_clock_rate == $past(i_wdata[8]))
    else $error("frame or clock select wrong");
  vcxo_pulse_a: assert property (
    o_vcxo_sync |=> !o_vcxo_sync)
    else $error("sync pulse too long");
endmodule
bind ctw_regs ctw_regs_checker #(.ID_CODE(ID_CODE)) u_chk (
  .i_mclk, .i_reset_n, .i_cs, .i_wr, .i_addr, .i_wdata, .o_rdata,
  .o_token_out, .o_mem_grant, .o_watchdog_out, .o_circuit_reset_n,
  .o_vcxo_sync, .o_frame_type, .o_bit_clock_rate
);
`default_nettype wire

// *** verif/ctw_ring_peer.sv ***
`default_nettype none
module ctw_ring_peer #(
  parameter int DELAY = 4
)
(
  // Clock
  input wire logic i_mclk,
  // Ring links
  input wire logic i_token_out,
  output logic o_token_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Starts idle so the relaunch counter never holds an unknown
  logic [3:0] cnt = 4'h0;
  always @(posedge i_mclk) begin
    if (i_token_out)
      cnt <= 4'(DELAY);
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    o_token_in <= cnt == 4'h2 || cnt == 4'h1;
  end
endmodule
`default_nettype wire

// *** verif/test_config_token_watchdog_regs.sv ***
`default_nettype none
module test_config_token_watchdog_regs
  import ctw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary value
  localparam logic [15:0] ID = 16'h5A5A;
  localparam int STEP = 10;
  logic i_mclk, i_reset_n, i_cs, i_wr, i_mem_req, i_vcxo_tick;
  logic i_hdlc_tx_seven, i_matrix_serial_in_seven;
  logic [1:0] i_addr;
  logic [15:0] i_wdata, i_timer_limit, rd, s0;
  wire logic i_token_in, o_mem_grant, o_token_out, o_watchdog_out;
  wire logic o_circuit_reset_n, o_vcxo_sync, o_matrix_in_seven;
  wire logic o_bit_clock_rate;
  wire logic [15:0] o_rdata, o_stamp;
  ctw_frame_type o_frame_type;
  int error_cnt = 0, n_checks = 0, n;
  ctw_regs #(.ID_CODE(ID), .STEP_CYCLES(STEP)) u_dut (
    .i_mclk, .i_reset_n, .i_cs, .i_wr, .i_addr, .i_wdata, .o_rdata,
    .i_token_in, .i_mem_req, .o_mem_grant, .o_token_out, .i_timer_limit,
    .o_watchdog_out, .o_stamp, .o_circuit_reset_n, .i_vcxo_tick,
    .o_vcxo_sync, .i_hdlc_tx_seven, .i_matrix_serial_in_seven,
    .o_matrix_in_seven, .o_frame_type, .o_bit_clock_rate
  );
  ctw_ring_peer #(.DELAY(4)) u_peer (
    .i_mclk, .i_token_out(o_token_out), .o_token_in(i_token_in)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out;
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] a,
                     input logic [15:0] d);
    @(posedge i_mclk);
    i_cs <= 1'b1;
    i_wr <= w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_cs <= 1'b0;
    #1 rd = o_rdata;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return o_token_out;
      1: return o_watchdog_out;
      default: return o_vcxo_sync;
    endcase
  endfunction
  // Counts cycles until the chosen output is seen high
  task automatic wait_hi(input int k, input int lim);
    n = 0;
    do begin
      @(posedge i_mclk);
      #1 n++;
    end while (sel(k) !== 1'b1 && n < lim);
    if (n >= lim) begin
      error_cnt++;
      $display("[FAIL] t=%0t wait %h limit %h", $time, k, lim);
      close_out();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(o_stamp, 16'h9999);
    acc(0, 2'h2, 16'h0000);
    chk(rd, 16'h0000);
    acc(0, 2'h0, 16'h0000);
    chk(rd, ID);
  endtask
  task automatic t_cmd;
    acc(1, 2'h2, 16'hFF00);
    acc(1, 2'h0, 16'hFFF8);
    acc(1, 2'h3, 16'h1234);
    acc(0, 2'h2, 16'h0000);
    chk(rd, 16'hFF00);
    chk(16'(o_bit_clock_rate), 16'h0001);
    for (int a = 1; a < 4; a += 2) begin
      acc(0, 2'(a), 16'h0000);
      chk(rd, 16'h0000);
    end
    acc(1, 2'h0, 16'h0004);
    chk(16'(o_circuit_reset_n), 16'h0000);
    acc(0, 2'h2, 16'h0000);
    chk(rd, 16'h0000);
    chk(16'(o_circuit_reset_n), 16'h0001);
    acc(0, 2'h0, 16'h0000);
    chk(rd, ID);
  endtask
  task automatic t_frame;
    for (int f = 0; f < 4; f++) begin
      acc(1, 2'h2, 16'(f << 6));
      chk(16'(o_frame_type), 16'(f));
    end
    chk(16'(o_bit_clock_rate), 16'h0000);
  endtask
  task automatic t_mux;
    for (int s = 0; s < 4; s++) begin
      acc(1, 2'h2, 16'(s / 2 * 32));
      @(posedge i_mclk);
      i_hdlc_tx_seven <= s[0];
      i_matrix_serial_in_seven <= !s[0];
      repeat (2) @(posedge i_mclk);
      #1 chk(16'(o_matrix_in_seven), 16'(s[1] ? s[0] : !s[0]));
    end
  endtask
  task automatic t_vcxo;
    for (int e = 0; e < 2; e++) begin
      acc(1, 2'h2, 16'(e << 4));
      wait_hi(2, 80);
      wait_hi(2, 80);
      chk(16'(n), e ? 16'h0020 : 16'h001E);
    end
  endtask
  task automatic t_stamp;
    acc(1, 2'h2, 16'h0008);
    // Restart lands one edge after the write; a later edge may step
    @(posedge i_mclk);
    #1 chk(o_stamp, 16'hFFFF);
    s0 = o_stamp;
    repeat (5 * STEP) @(posedge i_mclk);
    #1 chk(s0 - o_stamp, 16'h0005);
  endtask
  task automatic t_wdog;
    acc(1, 2'h2, 16'h0000);
    acc(1, 2'h0, 16'h0002);
    repeat (2) @(posedge i_mclk);
    for (int k = 0; k < 12; k++) begin
      acc(1, 2'h0, 16'h0002);
      chk(16'(o_watchdog_out), 16'h0000);
    end
    wait_hi(1, 20 * STEP);
    chk(16'(n >= 3 * STEP && n <= 5 * STEP), 16'h0001);
    acc(1, 2'h2, 16'h0001);
    repeat (2) @(posedge i_mclk);
    #1 chk(16'(o_watchdog_out), 16'h0000);
  endtask
  task automatic t_token;
    acc(1, 2'h0, 16'h0001);
    wait_hi(0, 10);
    wait_hi(0, 40);
    acc(1, 2'h2, 16'h0002);
    @(posedge i_mclk);
    i_mem_req <= 1'b1;
    repeat (40) @(posedge i_mclk);
    #1 chk(16'(o_mem_grant), 16'h0001);
    acc(1, 2'h2, 16'h0004);
    acc(1, 2'h0, 16'h0001);
    for (int k = 0; k < 30; k++) begin
      @(posedge i_mclk);
      #1 chk(16'({o_token_out, o_mem_grant}), 16'h0000);
    end
    acc(1, 2'h2, 16'h0000);
    acc(1, 2'h0, 16'h0001);
    wait_hi(0, 10);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    i_reset_n = 1'b0;
    i_cs = 1'b0;
    i_wr = 1'b0;
    i_addr = 2'h0;
    i_wdata = 16'h0000;
    i_mem_req = 1'b0;
    i_vcxo_tick = 1'b1;
    i_hdlc_tx_seven = 1'b0;
    i_matrix_serial_in_seven = 1'b0;
    i_timer_limit = 16'h0004;
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    #1 t_reset();
    t_cmd();
    t_frame();
    t_mux();
    t_vcxo();
    t_stamp();
    t_wdog();
    t_token();
    close_out();
  end
endmodule
`default_nettype wire
